/* tlb_consts.svh */
// constants of the translation lookaside block
`ifndef TLB_CONSTS_SVH
`define TLB_CONSTS_SVH
// Overview of operation
// - a 32-bit read-only register holds one accessed flag per table entry
// - flags read bit-reversed, entry 0 in bit 31, for leading-zero counting
// - no upper accessed-flags register exists; its slot is unmapped
// - one unified table of 32 entries with page, tag and attribute fields
// - loading an entry through the entry-write register sets its flag
// - a lookup match in an entry clears that entry's accessed flag
// - a 4-entry instruction and an 8-entry data micro-table feed caches
// - micro miss searches unified table, copies hit into micro table
// - no match anywhere raises a miss exception for that access side
// - micro replacement is hardware-only; a micro miss costs one cycle, two for a fetch waiting behind a data search
// - physical address joins frame bits with page offset per page size
// - unsegmented or zero/three segments: direct write-back if paging off
// - segmented privileged address in application mode: protection fault
// - segments two and four uncached, segment one write-back, untranslated
// - match needs valid, page equal, and shared mode or global or same tag
// - application mode with permission bit 2 clear: protection fault
// - data write with permission bit 1 clear: data protection fault
// - data write to a clean page: initial page write fault
// - fetch with execute permission bit 0 clear: protection fault
// - data policy: write-through if C and W, write-back if C, else uncached
// - fetch policy: cached if C set, uncached otherwise
// - more than one match raises multiple hit, steering to reset vector
// - mode bit 1 selects shared memory mode; with it clear, space tags are compared
// - enable bit turns page translation on; clear means no translation
`define TLB_ENTRIES    32
`define TLB_IMICRO     4
`define TLB_DMICRO     8
`define TLB_OFF_CTRL   8'h00
`define TLB_OFF_SPACE  8'h04
`define TLB_OFF_HI     8'h08
`define TLB_OFF_LO     8'h0C
`define TLB_OFF_LOAD   8'h10
`define TLB_OFF_ACC    8'h14
`define TLB_OFF_ACCHI  8'h18
`define TLB_OFF_STAT   8'h1C
`define TLB_OFF_FVA    8'h20
`define TLB_CTRL_PAGE  0
`define TLB_CTRL_SHR   1
`define TLB_CTRL_INV   2
`define TLB_CTRL_SEG   3
`define TLB_HI_VALID   9
`define TLB_LO_C       9
`define TLB_LO_G       8
`define TLB_LO_B       7
`define TLB_LO_D       0
`define TLB_LO_W       1
`define TLB_SEG_P1     3'h4
`define TLB_SEG_P2     3'h5
`define TLB_SEG_P3     3'h6
`define TLB_SEG_P4     3'h7
`define TLB_OFS_1K     32'h0000_03FF
`define TLB_OFS_4K     32'h0000_0FFF
`define TLB_OFS_64K    32'h0000_FFFF
`define TLB_OFS_1M     32'h000F_FFFF
`endif

/* tlb_pkg.sv */
// types and helpers of the translation lookaside block
`include "tlb_consts.svh"
package tlb_pkg;
    typedef struct packed {
        logic [21:0] virtual_page_number;
        logic [7:0]  space;
        logic        valid;
        logic [21:0] physical_frame_number;
        logic        cacheable;
        logic        global_pg;
        logic        bufferable;
        logic [2:0]  perm;
        logic [1:0]  size;
        logic        dirty;
        logic        wthru;
    } tlb_entry_t;
    typedef enum logic [2:0] {
        TLB_EXC_NONE  = 3'h0,
        TLB_EXC_MISS  = 3'h1,
        TLB_EXC_PROT  = 3'h2,
        TLB_EXC_MOD   = 3'h3,
        TLB_EXC_MULTI = 3'h4
    } tlb_exc_t;
    typedef enum logic [1:0] {
        TLB_POL_NC = 2'h0,
        TLB_POL_WB = 2'h1,
        TLB_POL_WT = 2'h2
    } tlb_policy_t;
    typedef enum logic [1:0] {
        TLB_ST_IDLE = 2'h0,
        TLB_ST_WAIT = 2'h1
    } tlb_state_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] va;
        logic        write;
        logic        app_mode;
    } tlb_req_t;
    typedef struct packed {
        logic        done;
        logic        access;
        logic [31:0] pa;
        tlb_policy_t policy;
        logic        bufferable;
        tlb_exc_t    exc;
        logic        is_instr;
        logic        is_write;
    } tlb_resp_t;
    function automatic logic [31:0] tlb_ofs_mask(input logic [1:0] sz);
        case (sz)
            2'b00:   return `TLB_OFS_1K;
            2'b01:   return `TLB_OFS_4K;
            2'b10:   return `TLB_OFS_64K;
            default: return `TLB_OFS_1M;
        endcase
    endfunction : tlb_ofs_mask
    function automatic logic tlb_vpn_hit(input tlb_entry_t e,
                                         input logic [31:0] va);
        logic [31:0] m;
        m = tlb_ofs_mask(e.size);
        return e.valid && ((({e.virtual_page_number, 10'h000} ^ va) & ~m) == 32'h0);
    endfunction : tlb_vpn_hit
endpackage : tlb_pkg

/* tlb_lookup.sv */
// translation lookaside block with micro-tables and register slave
`timescale 1ns/1ns
`include "tlb_consts.svh"

////////////////////////////////////////////////////////////////////////////
module tlb_micro_path
    import tlb_pkg::*;
#(
    parameter int DEPTH    = 4,
    parameter bit IS_INSTR = 1'b0
) (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // configuration
    input  wire logic       seg_en_i,
    input  wire logic       page_en_i,
    input  wire logic       flush_i,
    // pipeline side
    input  wire tlb_req_t   req_i,
    output logic            ready_o,
    output tlb_resp_t       resp_o,
    // unified table search
    output logic            uni_req_o,
    output logic [31:0]     uni_va_o,
    input  wire logic       uni_grant_i,
    input  wire logic       uni_hit_i,
    input  wire logic       uni_multi_i,
    input  wire tlb_entry_t uni_entry_i,
    input  wire logic [4:0] uni_idx_i,
    // micro hit for accessed flags
    output logic            mhit_o,
    output logic [4:0]      mhit_idx_o
);
    localparam int PW = (DEPTH > 4) ? 3 : 2;

    tlb_state_t       state_q;
    tlb_req_t         req_q;
    tlb_resp_t        resp_q;
    tlb_entry_t       ent_q [DEPTH];
    logic [4:0]       eidx_q [DEPTH];
    logic [DEPTH-1:0] ev_q;
    logic [PW-1:0]    rep_q;
    logic             m_hit;
    logic [PW-1:0]    m_sel;
    logic             go_paged;
    logic [2:0]       seg;
    tlb_resp_t        dir_r;

    function automatic tlb_resp_t finish(input tlb_entry_t e,
                                         input logic hit,
                                         input logic multi,
                                         input tlb_req_t r);
        tlb_resp_t o;
        o          = '0;
        o.done     = 1'b1;
        o.is_instr = IS_INSTR;
        o.is_write = r.write;
        o.exc      = TLB_EXC_NONE;
        if (multi) begin
            o.exc = TLB_EXC_MULTI;
        end else if (!hit) begin
            o.exc = TLB_EXC_MISS;
        end else if (r.app_mode && !e.perm[2]) begin
            o.exc = TLB_EXC_PROT;
        end else if (IS_INSTR && !e.perm[0]) begin
            o.exc = TLB_EXC_PROT;
        end else if (!IS_INSTR && r.write && !e.perm[1]) begin
            o.exc = TLB_EXC_PROT;
        end else if (!IS_INSTR && r.write && !e.dirty) begin
            o.exc = TLB_EXC_MOD;
        end
        o.access = (o.exc == TLB_EXC_NONE);
        o.pa     = ({e.physical_frame_number, 10'h000} & ~tlb_ofs_mask(e.size))
                 | (r.va & tlb_ofs_mask(e.size));
        o.bufferable = e.bufferable;
        if (!e.cacheable) begin
            o.policy = TLB_POL_NC;
        end else if (!IS_INSTR && e.wthru) begin
            o.policy = TLB_POL_WT;
        end else begin
            o.policy = TLB_POL_WB;
        end
        return o;
    endfunction : finish

    ////////////////////////////////////////////////////////////////////////
    // micro-table search; entries only survive while the context is
    // unchanged, so the space tag needs no second compare here
    always_comb begin
        m_hit = 1'b0;
        m_sel = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (ev_q[i] && tlb_vpn_hit(ent_q[i], req_i.va)) begin
                m_hit = 1'b1;
                m_sel = PW'(i);
            end
        end
    end

    // segment decode of a new request
    always_comb begin
        seg            = req_i.va[31:29];
        go_paged       = 1'b0;
        dir_r          = '0;
        dir_r.done     = 1'b1;
        dir_r.access   = 1'b1;
        dir_r.pa       = req_i.va;
        dir_r.policy   = TLB_POL_WB;
        dir_r.exc      = TLB_EXC_NONE;
        dir_r.is_instr = IS_INSTR;
        dir_r.is_write = req_i.write;
        if (!seg_en_i) begin
            go_paged = page_en_i;
        end else if (req_i.va[31] && req_i.app_mode) begin
            dir_r.exc    = TLB_EXC_PROT;
            dir_r.access = 1'b0;
        end else if (seg == `TLB_SEG_P4 || seg == `TLB_SEG_P2) begin
            dir_r.policy = TLB_POL_NC;
        end else if (seg == `TLB_SEG_P1) begin
            dir_r.policy = TLB_POL_WB;
        end else begin
            go_paged = page_en_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= TLB_ST_IDLE;
            req_q   <= '0;
        end else begin
            case (state_q)
                TLB_ST_IDLE: begin
                    if (req_i.valid) begin
                        req_q <= req_i;
                        if (go_paged && !m_hit) begin
                            state_q <= TLB_ST_WAIT;
                        end
                    end
                end
                TLB_ST_WAIT: begin
                    if (uni_grant_i) begin
                        state_q <= TLB_ST_IDLE;
                    end
                end
                default: state_q <= TLB_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            resp_q <= '0;
        end else if (state_q == TLB_ST_IDLE && req_i.valid) begin
            if (!go_paged) begin
                resp_q <= dir_r;
            end else if (m_hit) begin
                resp_q <= finish(ent_q[m_sel], 1'b1, 1'b0, req_i);
            end else begin
                resp_q.done <= 1'b0;
            end
        end else if (state_q == TLB_ST_WAIT && uni_grant_i) begin
            resp_q <= finish(uni_entry_i, uni_hit_i, uni_multi_i, req_q);
        end else begin
            resp_q.done <= 1'b0;
        end
    end

    // round-robin refill, invisible to software
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ev_q  <= '0;
            rep_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                ent_q[i]  <= '0;
                eidx_q[i] <= 5'h00;
            end
        end else if (flush_i) begin
            ev_q <= '0;
        end else if (state_q == TLB_ST_WAIT && uni_grant_i
                     && uni_hit_i && !uni_multi_i) begin
            ent_q[rep_q]  <= uni_entry_i;
            eidx_q[rep_q] <= uni_idx_i;
            ev_q[rep_q]   <= 1'b1;
            rep_q <= (rep_q == PW'(DEPTH - 1)) ? '0 : rep_q + 1'b1;
        end
    end

    assign ready_o    = (state_q == TLB_ST_IDLE);
    assign resp_o     = resp_q;
    assign uni_req_o  = (state_q == TLB_ST_WAIT);
    assign uni_va_o   = req_q.va;
    assign mhit_o     = ready_o && req_i.valid && go_paged && m_hit;
    assign mhit_idx_o = eidx_q[m_sel];
endmodule : tlb_micro_path

////////////////////////////////////////////////////////////////////////////
module tlb_lookup
    import tlb_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // register bus
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // instruction fetch side
    input  wire tlb_req_t    ireq_i,
    output logic             iready_o,
    output tlb_resp_t        iresp_o,
    // data access side
    input  wire tlb_req_t    dreq_i,
    output logic             dready_o,
    output tlb_resp_t        dresp_o,
    // critical error
    output logic             multi_hit_reset_o
);
    logic        page_en_q;
    logic        shared_q;
    logic        seg_en_q;
    logic [7:0]  space_q;
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic [4:0]  lidx_q;
    logic [31:0] acc_q;
    logic [31:0] prdata_q;
    logic [3:0]  stat_q;
    logic [31:0] fva_q;
    tlb_entry_t  table_q [`TLB_ENTRIES];
    tlb_entry_t  new_ent;
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic        flush;
    logic        load;
    logic        inval;
    logic [31:0] acc_rev;
    logic [31:0] rd_mux;
    logic        i_ureq;
    logic        d_ureq;
    logic [31:0] i_uva;
    logic [31:0] d_uva;
    logic        gnt_i;
    logic        gnt_d;
    logic [31:0] sva;
    logic        u_hit;
    logic        u_multi;
    logic [4:0]  u_idx;
    logic        i_mhit;
    logic        d_mhit;
    logic [4:0]  i_midx;
    logic [4:0]  d_midx;

    ////////////////////////////////////////////////////////////////////////
    // bus decode; the upper accessed-flags slot answers with an error
    assign wr_en    = psel_i && penable_i && pwrite_i && mapped;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign mapped   = (paddr_i[31:8] == 24'h0) && (paddr_i[1:0] == 2'h0)
                   && (paddr_i[7:0] <= `TLB_OFF_FVA)
                   && (paddr_i[7:0] != `TLB_OFF_ACCHI);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o  = prdata_q;
    assign load  = wr_en && (paddr_i[7:0] == `TLB_OFF_LOAD);
    assign inval = wr_en && (paddr_i[7:0] == `TLB_OFF_CTRL)
                && pwdata_i[`TLB_CTRL_INV];
    // any context change drops micro copies rather than rechecking them
    assign flush = wr_en && (paddr_i[7:0] == `TLB_OFF_CTRL
                || paddr_i[7:0] == `TLB_OFF_SPACE || load);

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            page_en_q <= 1'b0;
            shared_q  <= 1'b0;
            seg_en_q  <= 1'b1;
            space_q   <= 8'h00;
            hi_q      <= 32'h0000_0000;
            lo_q      <= 32'h0000_0000;
            lidx_q    <= 5'h00;
        end else if (wr_en) begin
            case (paddr_i[7:0])
                `TLB_OFF_CTRL: begin
                    page_en_q <= pwdata_i[`TLB_CTRL_PAGE];
                    shared_q  <= pwdata_i[`TLB_CTRL_SHR];
                    seg_en_q  <= pwdata_i[`TLB_CTRL_SEG];
                end
                `TLB_OFF_SPACE: space_q <= pwdata_i[7:0];
                `TLB_OFF_HI:    hi_q    <= pwdata_i;
                `TLB_OFF_LO:    lo_q    <= pwdata_i;
                `TLB_OFF_LOAD:  lidx_q  <= pwdata_i[4:0];
                default:        lidx_q  <= lidx_q;
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            acc_rev[31 - i] = acc_q[i];
        end
    end

    always_comb begin
        case (paddr_i[7:0])
            `TLB_OFF_CTRL:  rd_mux = {28'h0, seg_en_q, 1'b0,
                                      shared_q, page_en_q};
            `TLB_OFF_SPACE: rd_mux = {24'h0, space_q};
            `TLB_OFF_HI:    rd_mux = hi_q;
            `TLB_OFF_LO:    rd_mux = lo_q;
            `TLB_OFF_LOAD:  rd_mux = {27'h0, lidx_q};
            `TLB_OFF_ACC:   rd_mux = acc_rev;
            `TLB_OFF_STAT:  rd_mux = {28'h0, stat_q};
            `TLB_OFF_FVA:   rd_mux = fva_q;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= mapped ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unified table
    always_comb begin
        new_ent            = '0;
        new_ent.virtual_page_number        = hi_q[31:10];
        new_ent.valid      = hi_q[`TLB_HI_VALID];
        new_ent.space      = hi_q[7:0];
        new_ent.physical_frame_number        = lo_q[31:10];
        new_ent.cacheable  = lo_q[`TLB_LO_C];
        new_ent.global_pg  = lo_q[`TLB_LO_G];
        new_ent.bufferable = lo_q[`TLB_LO_B];
        new_ent.perm       = lo_q[6:4];
        new_ent.size       = lo_q[3:2];
        new_ent.wthru      = lo_q[`TLB_LO_W];
        new_ent.dirty      = lo_q[`TLB_LO_D];
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < `TLB_ENTRIES; i++) begin
                table_q[i] <= '0;
            end
        end else if (inval) begin
            for (int i = 0; i < `TLB_ENTRIES; i++) begin
                table_q[i].valid <= 1'b0;
            end
        end else if (load) begin
            table_q[pwdata_i[4:0]] <= new_ent;
        end
    end

    // data side wins the shared search port
    assign gnt_d = d_ureq;
    assign gnt_i = i_ureq && !d_ureq;
    assign sva   = gnt_d ? d_uva : i_uva;

    always_comb begin
        u_hit   = 1'b0;
        u_multi = 1'b0;
        u_idx   = 5'h00;
        for (int i = 0; i < `TLB_ENTRIES; i++) begin
            if (tlb_vpn_hit(table_q[i], sva)
                && (shared_q || table_q[i].global_pg
                    || table_q[i].space == space_q)) begin
                u_multi = u_multi || u_hit;
                u_hit   = 1'b1;
                u_idx   = 5'(i);
            end
        end
    end

    // a load in the same cycle as a match keeps the flag set
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_q <= 32'h0000_0000;
        end else begin
            if ((gnt_i || gnt_d) && u_hit) begin
                acc_q[u_idx] <= 1'b0;
            end
            if (i_mhit) begin
                acc_q[i_midx] <= 1'b0;
            end
            if (d_mhit) begin
                acc_q[d_midx] <= 1'b0;
            end
            if (load) begin
                acc_q[pwdata_i[4:0]] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault capture for software
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stat_q <= 4'h0;
            fva_q  <= 32'h0000_0000;
        end else if (dresp_o.done && dresp_o.exc != TLB_EXC_NONE) begin
            stat_q <= {1'b0, dresp_o.exc};
            fva_q  <= d_uva;
        end else if (iresp_o.done && iresp_o.exc != TLB_EXC_NONE) begin
            stat_q <= {1'b1, iresp_o.exc};
            fva_q  <= i_uva;
        end
    end

    assign multi_hit_reset_o =
        (iresp_o.done && iresp_o.exc == TLB_EXC_MULTI)
        || (dresp_o.done && dresp_o.exc == TLB_EXC_MULTI);

    ////////////////////////////////////////////////////////////////////////
    tlb_micro_path #(
        .DEPTH    (`TLB_IMICRO),
        .IS_INSTR (1'b1)
    ) u_ipath (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .seg_en_i    (seg_en_q),
        .page_en_i   (page_en_q),
        .flush_i     (flush),
        .req_i       (ireq_i),
        .ready_o     (iready_o),
        .resp_o      (iresp_o),
        .uni_req_o   (i_ureq),
        .uni_va_o    (i_uva),
        .uni_grant_i (gnt_i),
        .uni_hit_i   (u_hit),
        .uni_multi_i (u_multi),
        .uni_entry_i (table_q[u_idx]),
        .uni_idx_i   (u_idx),
        .mhit_o      (i_mhit),
        .mhit_idx_o  (i_midx)
    );

    tlb_micro_path #(
        .DEPTH    (`TLB_DMICRO),
        .IS_INSTR (1'b0)
    ) u_dpath (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .seg_en_i    (seg_en_q),
        .page_en_i   (page_en_q),
        .flush_i     (flush),
        .req_i       (dreq_i),
        .ready_o     (dready_o),
        .resp_o      (dresp_o),
        .uni_req_o   (d_ureq),
        .uni_va_o    (d_uva),
        .uni_grant_i (gnt_d),
        .uni_hit_i   (u_hit),
        .uni_multi_i (u_multi),
        .uni_entry_i (table_q[u_idx]),
        .uni_idx_i   (u_idx),
        .mhit_o      (d_mhit),
        .mhit_idx_o  (d_midx)
    );
endmodule : tlb_lookup

/* tlb_lookup_props.sv */
// assertion checker for the translation block ports
`timescale 1ns/1ns
module tlb_lookup_props
    import tlb_pkg::*;
(
    // clock and reset
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    // register bus
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // lookup sides
    input wire tlb_req_t    ireq_i,
    input wire logic        iready_o,
    input wire tlb_resp_t   iresp_o,
    input wire tlb_req_t    dreq_i,
    input wire logic        dready_o,
    input wire tlb_resp_t   dresp_o,
    input wire logic        multi_hit_reset_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    AST_UNMAP: assert property (
        psel_i && penable_i && paddr_i == 32'h18 |-> pslverr_o)
        else $error("upper flags slot not refused");
    // the fetch side may wait behind data searches, hence the wide bound
    AST_IANS: assert property (
        ireq_i.valid && iready_o |-> ##[1:40] iresp_o.done)
        else $error("fetch answer late");
    AST_DPEN: assert property (
        dreq_i.valid && dready_o ##1 !dready_o |=> dresp_o.done && dready_o)
        else $error("search penalty not one cycle");
    AST_DSUP: assert property (
        dresp_o.done && dresp_o.exc != TLB_EXC_NONE
        |-> !dresp_o.access && !dresp_o.is_instr)
        else $error("data fault not suppressed");
    AST_ISUP: assert property (
        iresp_o.done && iresp_o.exc != TLB_EXC_NONE
        |-> !iresp_o.access && iresp_o.is_instr)
        else $error("fetch fault not suppressed");
    AST_MULTI: assert property (
        multi_hit_reset_o |-> iresp_o.done && !iresp_o.access
        || dresp_o.done && !dresp_o.access)
        else $error("reset steer disagrees with multiple hit");
    AST_IPOL: assert property (
        iresp_o.done && iresp_o.access |-> iresp_o.policy != TLB_POL_WT)
        else $error("fetch given write policy");
    AST_DWR: assert property (
        dreq_i.valid && dready_o && dreq_i.write ##1 dready_o
        |-> dresp_o.done && dresp_o.is_write)
        else $error("store not reported as write");
endmodule : tlb_lookup_props

/* tlb_pipe_model.sv */
// pipeline request model, holds each request until taken
`timescale 1ns/1ns
module tlb_pipe_model
    import tlb_pkg::*;
(
    // clock and reset
    input  wire logic     clock_i,
    input  wire logic     sys_rst_i,
    // command from bench
    input  wire logic     go_i,
    input  wire tlb_req_t cmd_i,
    // design side
    input  wire logic     ready_i,
    output tlb_req_t      req_o
);
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_o <= '0;
        end else if (go_i) begin
            req_o <= cmd_i;
        end else if (req_o.valid && ready_i) begin
            // released fields scrambled so stale values are never trusted
            req_o <= {1'b0, ~req_o.va, ~req_o.write, ~req_o.app_mode};
        end
    end
endmodule : tlb_pipe_model

/* tlb_lookup_translation_tb.sv */
// self-checking bench of the translation block
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH %0t %h %h", $time, a, b); end end
module tlb_lookup_translation_tb;
    import tlb_pkg::*;
    logic        clock_i, sys_rst_i, psel_i, penable_i, pwrite_i, er;
    logic        pready_o, pslverr_o, iready_o, dready_o, multi_hit_reset_o;
    logic [31:0] paddr_i, pwdata_i, prdata_o, rd, va;
    logic [21:0] virtual_page_number [4];
    logic [21:0] physical_frame_number [4];
    logic [1:0]  go;
    tlb_req_t    ireq_i, dreq_i, cmd;
    tlb_resp_t   iresp_o, dresp_o, rs;
    int          n_fail, n_tests;
    tlb_lookup DUT (.*);
    tlb_pipe_model M_I (.clock_i, .sys_rst_i, .go_i(go[0]), .cmd_i(cmd),
                        .ready_i(iready_o), .req_o(ireq_i));
    tlb_pipe_model M_D (.clock_i, .sys_rst_i, .go_i(go[1]), .cmd_i(cmd),
                        .ready_i(dready_o), .req_o(dreq_i));
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    function automatic logic [31:0] msk(input int sz);
        return (32'h1 << (sz == 0 ? 10 : sz == 1 ? 12 : sz == 2 ? 16 : 20)) - 1;
    endfunction : msk
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clock_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic load(input int i, input logic [31:0] hi, lo);
        apb(1, 32'h08, hi);
        apb(1, 32'h0C, lo);
        apb(1, 32'h10, i);
    endtask : load
    task automatic look(input bit s, input logic [31:0] a, input logic w, p);
        int k;
        k = 0;
        @(posedge clock_i);
        go[s] <= 1'b1;
        cmd   <= {1'b1, a, w, p};
        @(posedge clock_i);
        go[s] <= 1'b0;
        do @(posedge clock_i);
        while ((s ? dresp_o.done : iresp_o.done) !== 1'b1 && ++k < 50);
        rs = s ? dresp_o : iresp_o;
        if (k >= 50) n_fail++;
    endtask : look
    task automatic print_verdict;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, go, cmd} = '0;
        sys_rst_i = 1'b1;
        void'($urandom(32'hA19C));
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        apb(0, 32'h14, 0); `CHK(rd, 32'h0)
        apb(0, 32'h18, 0); `CHK(er, 1'b1)
        for (int g = 4; g < 9; g++) begin
            va = {g[2:0], 29'h0ABC};
            look(1, va, 0, 0);
            `CHK(rs.policy, g[0] && g < 8 ? TLB_POL_NC : TLB_POL_WB)
            `CHK(rs.pa, va)
        end
        look(1, 32'h8000_0000, 0, 1); `CHK(rs.exc, TLB_EXC_PROT)
        apb(1, 32'h00, 32'h9);
        for (int i = 0; i < 4; i++) begin
            virtual_page_number[i] = {1'b0, i[1:0], 1'b0, 18'($urandom)};
            physical_frame_number[i] = 22'($urandom);
            load(i, {virtual_page_number[i], 10'h200}, {physical_frame_number[i], 10'(10'h271 | i << 2 | i[0] << 1)});
        end
        apb(0, 32'h14, 0); `CHK(rd, 32'hF000_0000)
        for (int i = 0; i < 4; i++) begin
            va = {virtual_page_number[i], 10'h0} | ($urandom & msk(i));
            look(1, va, 0, 1);
            `CHK(rs.pa, {physical_frame_number[i], 10'h0} & ~msk(i) | va & msk(i))
            `CHK(rs.policy, i[0] ? TLB_POL_WT : TLB_POL_WB)
        end
        apb(0, 32'h14, 0); `CHK(rd, 32'h0)
        look(0, {virtual_page_number[0], 10'h0}, 0, 0); `CHK(rs.policy, TLB_POL_WB)
        look(0, 32'h7FF0_0000, 0, 0); `CHK(rs.exc, TLB_EXC_MISS)
        look(1, 32'h7FF0_0000, 1, 0); `CHK(rs.exc, TLB_EXC_MISS)
        load(4, 32'h200, 32'h0);
        for (int c = 0; c < 4; c++) begin
            look(c != 3, 32'h0, c == 2, c == 0);
            `CHK(rs.exc, c == 1 ? TLB_EXC_NONE : TLB_EXC_PROT)
        end
        load(5, 32'h600, 32'h270);
        look(1, 32'h400, 1, 0); `CHK(rs.exc, TLB_EXC_MOD)
        load(6, 32'hA5A, 32'h271);
        look(1, 32'h800, 0, 0); `CHK(rs.exc, TLB_EXC_MISS)
        apb(1, 32'h04, 32'h5A);
        look(1, 32'h800, 0, 0); `CHK(rs.exc, TLB_EXC_NONE)
        apb(1, 32'h04, 32'h0);
        apb(1, 32'h00, 32'hB);
        look(1, 32'h800, 0, 0); `CHK(rs.exc, TLB_EXC_NONE)
        load(31, 32'hA5A, 32'h271);
        look(1, 32'h800, 0, 0); `CHK(rs.exc, TLB_EXC_MULTI)
        apb(1, 32'h00, 32'h8);
        look(1, 32'h800, 0, 0); `CHK(rs.pa, 32'h800)
        print_verdict();
    end
    initial begin
        #1_000_000;
        n_fail++;
        print_verdict();
    end
endmodule : tlb_lookup_translation_tb
bind tlb_lookup tlb_lookup_props CHK (.*);
